// *** shared/fsec_pkg.sv ***
// Package with constants and types for the flash erase sequencing controller.
// Operation
// - Host masks reserved status bit 0 whenever it polls status.
// - Block erase: poll bit 7 after 70H, then 20H, then D0H in block.
// - Host may chain block erasures and check status after each or all.
// - Chip erase: 30H then D0H at any address, poll bit 7 until ready.
// - After the final erase the host writes FFH for read-array mode.
// - On any error the host issues clear-status before retrying; the code clears only after an error seen in the check of a checked order.
package fsec_pkg;

  // Command bytes written to the device.
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_BLOCK_SETUP = 8'h20;
  localparam logic [7:0] CMD_CHIP_SETUP = 8'h30;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;

  // Status bit positions.
  localparam int ST_READY = 7;
  localparam int ST_ERASE_SUSP = 6;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_WRITE_ERR = 4;
  localparam int ST_SUPPLY_LOW = 3;
  localparam int ST_WRITE_SUSP = 2;
  localparam int ST_PROTECT = 1;
  localparam logic [7:0] ST_VALID_MASK = 8'hFE;

  // Bus timing, in ns and derived cycles at 100 MHz.
  localparam int CLK_PERIOD_NS = 10;
  localparam int WE_PULSE_NS = 50;
  localparam int RD_ACCESS_NS = 90;
  localparam int WE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WE_CYC_W = 4'(WE_CYC);
  localparam logic [3:0] RD_CYC_W = 4'(RD_CYC);

  // Address width of the parallel bus.
  localparam int AW = 20;

  // One bus access toward the device.
  typedef struct packed {
    logic wr;
    logic [AW-1:0] addr;
    logic [7:0] data;
  } fsec_access_t;

  // Error summary from the full status check.
  typedef struct packed {
    logic seq_err;
    logic erase_err;
    logic supply_low;
    logic protect;
  } fsec_err_t;

  // Sequencer states, Gray along the main path.
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_POLL0 = 4'h1,
    S_SETUP = 4'h3,
    S_CONFIRM = 4'h2,
    S_POLL1 = 4'h6,
    S_CHECK = 4'h7,
    S_CLEAR = 4'h5,
    S_ARRAY = 4'h4,
    S_DONE = 4'hC
  } fsec_state_t;

endpackage : fsec_pkg

// *** rtl/fsec_bus.sv ***
`timescale 1ns/1ps
// Single bus cycle engine driving the asynchronous parallel flash pins.
module fsec_bus (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Access request and reply.
  input wire logic req,
  input wire fsec_pkg::fsec_access_t acc,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  // Flash pins.
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [fsec_pkg::AW-1:0] addr,
  output logic [7:0] dq_o,
  output logic dq_oe,
  input wire logic [7:0] dq_i
);

  logic [3:0] cnt_ff;
  logic active_ff;
  logic wr_ff;
  wire last = (cnt_ff == 4'h1);

  // One access: strobe held for the timed count, data captured at its end.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      active_ff <= 1'b0;
      wr_ff <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= '0;
      dq_o <= 8'h00;
      dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      // Release the data bus one cycle after the write strobe rose, to keep hold time.
      if (done) begin
        dq_oe <= 1'b0;
      end
      if (!active_ff && req) begin
        active_ff <= 1'b1;
        wr_ff <= acc.wr;
        cnt_ff <= acc.wr ? fsec_pkg::WE_CYC_W : fsec_pkg::RD_CYC_W;
        addr <= acc.addr;
        dq_o <= acc.data;
        dq_oe <= acc.wr;
        ce_n <= 1'b0;
        we_n <= !acc.wr;
        oe_n <= acc.wr;
      end else if (active_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
        if (last) begin
          active_ff <= 1'b0;
          done <= 1'b1;
          ce_n <= 1'b1;
          we_n <= 1'b1;
          oe_n <= 1'b1;
          if (!wr_ff) begin
            rdata <= dq_i;
          end
        end
      end
    end
  end

  // Busy covers the whole strobe, so a new access can never overlap the last one.
  assign busy = active_ff;

endmodule : fsec_bus

// *** rtl/fsec_ctrl.sv ***
`timescale 1ns/1ps
// Host controller that sequences block and full chip erase on the flash.
module fsec_ctrl (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // User orders.
  input wire logic start,
  input wire logic chip_erase,
  input wire logic [fsec_pkg::AW-1:0] block_addr,
  input wire logic last_op,
  input wire logic check_each,
  // User results.
  output logic ready,
  output logic op_done,
  output logic [7:0] status,
  output fsec_pkg::fsec_err_t errors,
  // Flash pins.
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [fsec_pkg::AW-1:0] addr,
  output logic [7:0] dq_o,
  output logic dq_oe,
  input wire logic [7:0] dq_i,
  input wire logic ready_busy_n
);

  fsec_pkg::fsec_state_t state_ff, nxt_state;
  logic issued_ff;
  logic step_ff;
  logic chip_ff;
  logic last_ff;
  logic check_ff;
  logic [fsec_pkg::AW-1:0] blk_ff;
  logic [7:0] sts_ff;
  fsec_pkg::fsec_err_t err_ff;
  logic bus_busy;
  logic bus_done;
  logic [7:0] bus_rdata;
  fsec_pkg::fsec_access_t acc;

  // Status byte with the reserved bit masked, as polled.
  function automatic logic [7:0] masked(input logic [7:0] s);
    masked = s & fsec_pkg::ST_VALID_MASK;
  endfunction : masked

  wire [7:0] rd_sts = masked(bus_rdata);
  wire dev_ready = rd_sts[fsec_pkg::ST_READY];
  wire seq_err = rd_sts[fsec_pkg::ST_ERASE_ERR] & rd_sts[fsec_pkg::ST_WRITE_ERR];
  wire any_err = |(rd_sts & 8'h3A);
  wire in_read = (state_ff == fsec_pkg::S_POLL0) || (state_ff == fsec_pkg::S_POLL1);
  wire req = !bus_busy && !issued_ff && (state_ff != fsec_pkg::S_IDLE)
    && (state_ff != fsec_pkg::S_DONE) && (state_ff != fsec_pkg::S_CHECK);

  // Access chosen by state: one write of 70H, then reads while polling.
  always_comb begin
    acc.wr = 1'b1;
    acc.addr = '0;
    acc.data = fsec_pkg::CMD_READ_STATUS;
    case (state_ff)
      fsec_pkg::S_POLL0, fsec_pkg::S_POLL1: begin
        acc.wr = step_ff;
      end
      fsec_pkg::S_SETUP: begin
        acc.data = chip_ff ? fsec_pkg::CMD_CHIP_SETUP : fsec_pkg::CMD_BLOCK_SETUP;
      end
      fsec_pkg::S_CONFIRM: begin
        acc.data = fsec_pkg::CMD_CONFIRM;
        acc.addr = chip_ff ? '0 : blk_ff;
      end
      fsec_pkg::S_CLEAR: begin
        acc.data = fsec_pkg::CMD_CLEAR_STATUS;
      end
      fsec_pkg::S_ARRAY: begin
        acc.data = fsec_pkg::CMD_READ_ARRAY;
      end
      default: begin
        acc.wr = 1'b1;
      end
    endcase
  end

  // Next state; a busy device (bit 7 low) keeps the poll reading.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fsec_pkg::S_IDLE: begin
        if (start) begin
          nxt_state = fsec_pkg::S_POLL0;
        end
      end
      fsec_pkg::S_POLL0: begin
        if (bus_done && !step_ff && dev_ready) begin
          nxt_state = fsec_pkg::S_SETUP;
        end
      end
      fsec_pkg::S_SETUP: begin
        if (bus_done) begin
          nxt_state = fsec_pkg::S_CONFIRM;
        end
      end
      fsec_pkg::S_CONFIRM: begin
        if (bus_done) begin
          nxt_state = fsec_pkg::S_POLL1;
        end
      end
      fsec_pkg::S_POLL1: begin
        if (bus_done && !step_ff && dev_ready && ready_busy_n) begin
          nxt_state = fsec_pkg::S_CHECK;
        end
      end
      fsec_pkg::S_CHECK: begin
        // Unchecked erasures leave the flags in the device so that they accumulate.
        if (any_err && check_ff) begin
          nxt_state = fsec_pkg::S_CLEAR;
        end else if (last_ff) begin
          nxt_state = fsec_pkg::S_ARRAY;
        end else begin
          nxt_state = fsec_pkg::S_DONE;
        end
      end
      fsec_pkg::S_CLEAR: begin
        if (bus_done) begin
          nxt_state = last_ff ? fsec_pkg::S_ARRAY : fsec_pkg::S_DONE;
        end
      end
      fsec_pkg::S_ARRAY: begin
        if (bus_done) begin
          nxt_state = fsec_pkg::S_DONE;
        end
      end
      fsec_pkg::S_DONE: begin
        nxt_state = fsec_pkg::S_IDLE;
      end
      default: begin
        nxt_state = fsec_pkg::S_IDLE;
      end
    endcase
  end

  // State, order latch and poll step; step 1 is the 70H write, step 0 a read.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= fsec_pkg::S_IDLE;
      issued_ff <= 1'b0;
      step_ff <= 1'b1;
      chip_ff <= 1'b0;
      last_ff <= 1'b0;
      check_ff <= 1'b1;
      blk_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      issued_ff <= (nxt_state == state_ff) && (issued_ff || req) && !bus_done;
      if (nxt_state != state_ff) begin
        step_ff <= 1'b1;
      end else if (bus_done && in_read) begin
        step_ff <= 1'b0;
      end
      if (state_ff == fsec_pkg::S_IDLE && start) begin
        chip_ff <= chip_erase;
        last_ff <= last_op;
        check_ff <= check_each | chip_erase | last_op;
        blk_ff <= block_addr;
      end
    end
  end

  // Results; error flags accumulate across chained erasures until cleared.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sts_ff <= 8'h80;
      err_ff <= '0;
      ready <= 1'b1;
      op_done <= 1'b0;
    end else begin
      ready <= (nxt_state == fsec_pkg::S_IDLE);
      op_done <= (state_ff == fsec_pkg::S_DONE);
      if (bus_done && in_read && !step_ff) begin
        sts_ff <= rd_sts;
      end
      if (state_ff == fsec_pkg::S_CHECK && check_ff) begin
        err_ff.seq_err <= err_ff.seq_err | seq_err;
        err_ff.erase_err <= err_ff.erase_err | rd_sts[fsec_pkg::ST_ERASE_ERR];
        err_ff.supply_low <= err_ff.supply_low | rd_sts[fsec_pkg::ST_SUPPLY_LOW];
        err_ff.protect <= err_ff.protect | rd_sts[fsec_pkg::ST_PROTECT];
      end else if (state_ff == fsec_pkg::S_IDLE && start
                   && (chip_erase | check_each | last_op)) begin
        err_ff <= '0;
      end
    end
  end

  assign status = sts_ff;
  assign errors = err_ff;

  fsec_bus u_bus (
    .clock(clock),
    .rst(rst),
    .req(req),
    .acc(acc),
    .busy(bus_busy),
    .done(bus_done),
    .rdata(bus_rdata),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .addr(addr),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .dq_i(dq_i)
  );

  // Setup must be preceded by a poll that saw the device ready.
  property p_setup_after_ready;
    @(posedge clock) disable iff (rst)
      (state_ff == fsec_pkg::S_POLL0) && (nxt_state == fsec_pkg::S_SETUP) |-> dev_ready;
  endproperty
  a_setup_after_ready: assert property (p_setup_after_ready) else $error("setup before ready");

  // Confirm always follows setup directly.
  property p_confirm_follows;
    @(posedge clock) disable iff (rst)
      (state_ff == fsec_pkg::S_SETUP) && bus_done |=> (state_ff == fsec_pkg::S_CONFIRM);
  endproperty
  a_confirm_follows: assert property (p_confirm_follows) else $error("confirm missing");

  // Any error seen in the check of a checked order leads to the clear command next.
  property p_clear_on_error;
    @(posedge clock) disable iff (rst)
      (state_ff == fsec_pkg::S_CHECK) && any_err && check_ff |=> (state_ff == fsec_pkg::S_CLEAR);
  endproperty
  a_clear_on_error: assert property (p_clear_on_error) else $error("error not cleared");

  // Reserved bit never appears in the reported status.
  property p_mask_bit0;
    @(posedge clock) disable iff (rst) !status[0];
  endproperty
  a_mask_bit0: assert property (p_mask_bit0) else $error("reserved bit leaked");

  // Read-array command is written only when the order was the last one.
  property p_array_last;
    @(posedge clock) disable iff (rst)
      (state_ff == fsec_pkg::S_ARRAY) |-> last_ff;
  endproperty
  a_array_last: assert property (p_array_last) else $error("read array too early");

  // Every write strobe lasts the full pulse time and then rises again.
  sequence s_write_strobe;
    (!we_n) [*5] ##1 we_n;
  endsequence
  property p_write_pulse;
    @(posedge clock) disable iff (rst) $fell(we_n) |-> s_write_strobe;
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("bad write strobe");

  // The check step is entered only after a poll that read the device ready.
  property p_check_after_ready;
    @(posedge clock) disable iff (rst)
      (state_ff == fsec_pkg::S_CHECK) |-> status[fsec_pkg::ST_READY];
  endproperty
  a_check_after_ready: assert property (p_check_after_ready) else $error("not ready");

endmodule : fsec_ctrl

// *** tb/fsec_flash_model.sv ***
`timescale 1ns/1ps
// Behavioural flash device model answering the erase sequencer.
module fsec_flash_model (
  // Clock for the internal busy timer.
  input wire logic clock,
  // Flash pins.
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [fsec_pkg::AW-1:0] addr,
  input wire logic [7:0] dq_o,
  output logic [7:0] dq_i,
  output logic ready_busy_n,
  // Bench controls and observations.
  input wire logic [7:0] busy_cyc,
  input wire logic lock_set,
  input wire logic supply_low,
  output logic array_mode,
  output logic [fsec_pkg::AW-1:0] erased_addr,
  output int erase_cnt
);
  // Bit 0 reads 1 so that a host which forgets to mask it is caught.
  logic [7:0] sr_ff = 8'h01;
  logic [7:0] bcnt_ff = 8'h00;
  logic [7:0] wd_ff, last_ff = 8'h00;
  logic [fsec_pkg::AW-1:0] wa_ff;
  logic wl_ff = 1'b0;
  logic rd_status_ff = 1'b0;
  logic id_ff = 1'b0;
  logic [1:0] pend_ff = 2'd0;
  wire drive = !ce_n && !oe_n;
  // Suspend bits 6 and 2 stay 0: no suspend command is ever accepted.
  wire [7:0] rd_val = id_ff ? {7'h00, lock_set} :
    rd_status_ff ? {bcnt_ff == 8'h00, sr_ff[6:0]} : 8'hA5;
  // A released bus shows the inverse of its last value, never a held copy.
  assign dq_i = drive ? rd_val : ~last_ff;
  assign ready_busy_n = (bcnt_ff == 8'h00);
  initial array_mode = 1'b0;
  initial erase_cnt = 0;
  // A command is latched while the write strobe is low and acted on once it rises.
  always @(posedge clock) begin
    if (drive) last_ff <= rd_val;
    if (bcnt_ff != 8'h00) bcnt_ff <= bcnt_ff - 8'h01;
    if (!we_n && !ce_n) begin
      wd_ff <= dq_o;
      wa_ff <= addr;
      wl_ff <= 1'b1;
    end else if (wl_ff) begin
      wl_ff <= 1'b0;
      array_mode <= 1'b0;
      // Identifier mode shows the lock state as a configuration code.
      id_ff <= (pend_ff == 2'd0) && (wd_ff == 8'h90);
      if (pend_ff != 2'd0) begin
        rd_status_ff <= 1'b1;
        pend_ff <= 2'd0;
        if (wd_ff != 8'hD0) begin
          sr_ff <= sr_ff | 8'h30;
        end else begin
          erase_cnt <= erase_cnt + 1;
          erased_addr <= wa_ff;
          // Locks and supply reach the status only here, never continuously.
          if (supply_low) sr_ff <= sr_ff | 8'h28;
          else if (lock_set && pend_ff == 2'd1) sr_ff <= sr_ff | 8'h22;
          else bcnt_ff <= busy_cyc;
        end
      end else begin
        case (wd_ff)
          8'h70: rd_status_ff <= 1'b1;
          8'h20: pend_ff <= 2'd1;
          8'h30: pend_ff <= 2'd2;
          8'h50: sr_ff <= sr_ff & 8'hC5;
          8'hFF: begin
            rd_status_ff <= 1'b0;
            array_mode <= 1'b1;
          end
          default: sr_ff <= sr_ff;
        endcase
      end
    end
  end
endmodule : fsec_flash_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
// Self-checking testbench for the erase sequencer against the flash model.
module testbench;
  logic clock, rst, start, chip_erase, last_op, check_each, ready, op_done;
  logic ce_n, oe_n, we_n, dq_oe, rbn, lock_set, supply_low, array_mode;
  logic [19:0] block_addr, addr, erased_addr;
  logic [7:0] status, dq_o, dq_i, busy_cyc, sticky;
  fsec_pkg::fsec_err_t errors;
  int erase_cnt, err_count, samples_checked, cyc;
  fsec_ctrl i_fsec_ctrl (.clock(clock), .rst(rst), .start(start), .chip_erase(chip_erase),
    .block_addr(block_addr), .last_op(last_op), .check_each(check_each), .ready(ready),
    .op_done(op_done), .status(status), .errors(errors), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .ready_busy_n(rbn));
  fsec_flash_model i_fsec_flash_model (.clock(clock), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .dq_o(dq_o), .dq_i(dq_i), .ready_busy_n(rbn), .busy_cyc(busy_cyc),
    .lock_set(lock_set), .supply_low(supply_low), .array_mode(array_mode),
    .erased_addr(erased_addr), .erase_cnt(erase_cnt));
  // Free-running clock at 100 MHz.
  always #5 clock = ~clock;
  // Cycle ceiling well above forty orders of at most about 130 cycles each.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      $display("Error at %0t: run hung", $time);
      end_of_test();
    end
  end
  // Value compare; four-state so an unknown never matches.
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val
  // Expected sticky device bits after one erase attempt.
  function automatic logic [7:0] next_sticky(logic [7:0] s, logic chip, logic lk, logic lo);
    if (lo) return s | 8'h28;
    if (lk && !chip) return s | 8'h22;
    return s;
  endfunction : next_sticky
  // One erase order, optionally poked with a start that must be ignored.
  task automatic run(input logic chip, input logic [19:0] ba, input logic last,
                     input logic chk, input logic lk, input logic lo, input logic [7:0] bc,
                     input logic poke);
    int n;
    int cnt0;
    cnt0 = erase_cnt;
    chip_erase = chip;
    block_addr = ba;
    last_op = last;
    check_each = chk;
    lock_set = lk;
    supply_low = lo;
    busy_cyc = bc;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    if (poke) begin
      repeat (3) @(negedge clock);
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
    end
    n = 0;
    while (op_done !== 1'b1 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    chk_val(32'(op_done), 32'h1, "op_done");
    sticky = next_sticky(sticky, chip, lk, lo);
    chk_val(32'(status), 32'({2'b10, sticky[5:1], 1'b0}), "status");
    chk_val(32'(status[0]), 32'h0, "reserved bit");
    chk_val(erase_cnt, cnt0 + 1, "erase count");
    if (!chip) chk_val(32'(erased_addr), 32'(ba), "confirm address");
    chk_val(32'(array_mode), 32'(last), "read array");
    if (chip || chk || last) begin
      chk_val(32'(errors), 32'({sticky[5] & sticky[4], sticky[5], sticky[3], sticky[1]}),
              "errors");
      sticky = 8'h00;
    end
    @(negedge clock);
    chk_val(32'(ready), 32'h1, "ready again");
    $display("test done: chip %0b lock %0b low %0b", chip, lk, lo);
  endtask : run
  // Final verdict, reached from the main sequence or the ceiling.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  // Reset, hand-picked corner orders, then random chains.
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    chip_erase = 1'b0;
    block_addr = 20'h00000;
    last_op = 1'b0;
    check_each = 1'b0;
    busy_cyc = 8'h0A;
    lock_set = 1'b0;
    supply_low = 1'b0;
    sticky = 8'h00;
    err_count = 0;
    samples_checked = 0;
    cyc = 0;
    void'($urandom(32'hCF53));
    repeat (20) @(negedge clock);
    rst = 1'b0;
    chk_val(32'({ready, status, errors, ce_n, oe_n, we_n, dq_oe}),
            32'({1'b1, 8'h80, 4'h0, 3'b111, 1'b0}), "reset");
    run(1'b1, 20'h00000, 1'b1, 1'b1, 1'b0, 1'b0, 8'h01, 1'b1);
    run(1'b0, 20'hFFFFF, 1'b0, 1'b0, 1'b1, 1'b0, 8'h28, 1'b0);
    run(1'b0, 20'h12345, 1'b0, 1'b0, 1'b0, 1'b1, 8'h05, 1'b0);
    run(1'b0, 20'h00001, 1'b1, 1'b1, 1'b0, 1'b0, 8'h3C, 1'b1);
    run(1'b1, 20'h00000, 1'b0, 1'b1, 1'b1, 1'b0, 8'h14, 1'b0);
    repeat (35) begin
      run(1'($urandom % 4 == 0), 20'($urandom), 1'($urandom), 1'($urandom),
          1'($urandom % 4 == 0), 1'($urandom % 8 == 0), 8'($urandom % 60 + 1),
          1'($urandom));
    end
    end_of_test();
  end
endmodule : testbench
